// file: rtl/optical_ctrl_defines.vh
// Constants for the optical module control logic.
// How it works
// [RQ1] Effective rate pick is pin level OR software select bit.
// [RQ2] Decoding applies only when rate id byte matches code and enable bit set.
// [RQ3] Pick pair 00 low lock, 01 rx high tx bypass, 10 both bypass, 11 high.
// [RQ4] Low and high rates come from the rate identification byte.
// [RQ5] Transmitter off while disable input is high or left open.
// [RQ6] Transmit output off within 100 us after disable rises.
// [RQ7] Transmit output back within 2 ms after disable falls, normal operation.
// [RQ8] Transmit fault output high on a laser fault condition.
// [RQ9] Transmit fault asserted within 1 ms of the fault.
// [RQ10] Host holds disable high at least 10 us to clear a fault.
// [RQ11] Signal lost output high when optical level below threshold.
// [RQ12] Signal lost asserted within 100 us of signal loss.
// [RQ13] Signal lost released within 100 us of signal return.
// [RQ14] Stable output within 500 us in fibre channel, else 24 ms.
// [RQ15] Unconnected rate pick pins read as zero.
// [RQ16] Presence output is grounded, so driven low.
// [RQ17] Serial interface ready within 300 ms of power on.
// [RQ18] Fully operational at power level one within 300 ms.
// [RQ19] Power level two entry complete within 300 ms after stop.
// [RQ20] Power level two exit complete within 300 ms after stop.
// [RQ21] Identification and diagnostics readable over serial interface.
// [RQ22] Host inputs synchronised; fault stays latched until reset sequence.
`ifndef OPTICAL_CTRL_DEFINES_VH
`define OPTICAL_CTRL_DEFINES_VH
`define CLK_PERIOD_NS      100
`define RATE_CODE          8'h0e
`define T_OFF_US           100
`define T_ON_MS            2
`define T_FAULT_ON_MS      1
`define T_RESET_US         10
`define T_LOS_US           100
`define T_RS_FC_US         500
`define T_RS_MS            24
`define T_START_MS         300
`define CYC_OFF            ((`T_OFF_US * 1000) / `CLK_PERIOD_NS)
`define CYC_ON             ((`T_ON_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_FAULT          ((`T_FAULT_ON_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_RESET          ((`T_RESET_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_LOS            ((`T_LOS_US * 1000) / `CLK_PERIOD_NS)
`define CYC_RS_FC          ((`T_RS_FC_US * 1000) / `CLK_PERIOD_NS)
`define CYC_RS             ((`T_RS_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_START          ((`T_START_MS * 1000000) / `CLK_PERIOD_NS)
`define CDR_LOCK_LOW       2'h0
`define CDR_LOCK_HIGH      2'h1
`define CDR_BYPASS         2'h2
`endif

// file: rtl/level_filter.v
// Synchroniser plus debounce counter for one level input.
`timescale 1ns/1ps
module level_filter #(
    parameter [24:0] HOLD = 25'h1
) (
    // Clock and control.
    input  wire ref_clk_i,
    input  wire reset_i,
    input  wire enable_i,
    input  wire init_i,
    // Level.
    input  wire level_i,
    output reg  level_o,
    output reg  sync_o
);
    reg        meta_r;
    reg [24:0] count_r;

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_r  <= 1'b0;
            sync_o  <= 1'b0;
            level_o <= 1'b0;
            count_r <= 25'h0;
        end else if (enable_i) begin
            meta_r <= level_i; // [RQ22]
            sync_o <= meta_r;
            if (init_i) begin
                level_o <= sync_o;
                count_r <= 25'h0;
            end else if (sync_o == level_o) begin
                count_r <= 25'h0;
            end else if (count_r + 25'h1 >= HOLD) begin
                level_o <= sync_o;
                count_r <= 25'h0;
            end else begin
                count_r <= count_r + 25'h1;
            end
        end
    end
endmodule // level_filter

// file: rtl/optical_ctrl.v
// Low-speed control and status logic of the optical module.
`timescale 1ns/1ps
`include "optical_ctrl_defines.vh"
module optical_ctrl #(
    parameter [24:0] START_CYC = `CYC_START,
    parameter [24:0] ON_CYC    = `CYC_ON,
    parameter [24:0] FAULT_CYC = `CYC_FAULT,
    parameter [24:0] RS_CYC    = `CYC_RS
) (
    // Clock, reset, enable.
    input  wire       ref_clk_i,
    input  wire       reset_i,
    input  wire       clk_en_i,
    // Host pins.
    input  wire       tx_disable_i,
    input  wire       tx_disable_open_i,
    input  wire       receive_rate_pick_i,
    input  wire       transmit_rate_pick_i,
    // Serial interface side.
    input  wire       soft_rx_pick_i,
    input  wire       soft_tx_pick_i,
    input  wire [7:0] rate_id_i,
    input  wire       rate_sel_en_i,
    input  wire       fc_mode_i,
    input  wire       high_power_req_i,
    input  wire       stop_seen_i,
    // Analog side.
    input  wire       laser_fault_i,
    input  wire       signal_low_i,
    // Outputs.
    output reg        laser_on_o,
    output reg        tx_fault_o,
    output reg        rx_los_o,
    output reg        module_missing_o,
    output reg  [1:0] rx_cdr_mode_o,
    output reg  [1:0] tx_cdr_mode_o,
    output reg  [3:0] cdr_rate_o,
    output reg        rate_stable_o,
    output reg        serial_ready_o,
    output reg        operational_o,
    output reg        high_power_o,
    output reg        power_settled_o
);
    localparam [1:0] ST_START = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_OFF   = 2'h2;
    localparam [1:0] ST_FAULT = 2'h3;

    localparam [24:0] OFF_CYC   = `CYC_OFF;
    localparam [24:0] RST_CYC   = `CYC_RESET;
    localparam [24:0] RSFC_CYC  = `CYC_RS_FC;
    localparam [24:0] LOS_CYC   = `CYC_LOS;
    localparam [7:0]  RATE_CODE = `RATE_CODE;

    wire       dis_lvl;
    wire       dis_raw;
    wire       fault_lvl;
    wire       los_lvl;
    wire       rxp_lvl;
    wire       txp_lvl;
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg [24:0] timer_r;
    reg [24:0] dis_hold_r;
    reg [24:0] rs_timer_r;
    reg [24:0] pwr_timer_r;
    reg        pick_prev_r;
    reg        hp_pending_r;
    reg        fault_latch_r;
    reg        init_r;
    reg  [1:0] init_cnt_r;
    wire       rx_pick;
    wire       tx_pick;
    wire       decode_on;
    wire       pick_any;
    wire [24:0] rs_limit;

    // Disable reads high when open because of the internal pull-up.
    wire dis_pin = tx_disable_i | tx_disable_open_i; // [RQ5]

    level_filter #(.HOLD(25'h1)) u_dis (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .enable_i  (clk_en_i),
        .init_i    (init_r),
        .level_i   (dis_pin),
        .level_o   (dis_lvl),
        .sync_o    (dis_raw)
    );

    level_filter #(.HOLD(25'h1)) u_flt (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .enable_i  (clk_en_i),
        .init_i    (init_r),
        .level_i   (laser_fault_i),
        .level_o   (fault_lvl),
        .sync_o    ()
    );

    level_filter #(.HOLD(LOS_CYC - 25'h4)) u_los (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .enable_i  (clk_en_i),
        .init_i    (init_r),
        .level_i   (signal_low_i),
        .level_o   (los_lvl), // [RQ11]
        .sync_o    ()
    );

    level_filter #(.HOLD(25'h1)) u_rxp (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .enable_i  (clk_en_i),
        .init_i    (init_r),
        .level_i   (receive_rate_pick_i), // [RQ15]
        .level_o   (rxp_lvl),
        .sync_o    ()
    );

    level_filter #(.HOLD(25'h1)) u_txp (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .enable_i  (clk_en_i),
        .init_i    (init_r),
        .level_i   (transmit_rate_pick_i), // [RQ15]
        .level_o   (txp_lvl),
        .sync_o    ()
    );

    assign rx_pick   = rxp_lvl | soft_rx_pick_i; // [RQ1]
    assign tx_pick   = txp_lvl | soft_tx_pick_i; // [RQ1]
    assign decode_on = (rate_id_i == RATE_CODE) & rate_sel_en_i; // [RQ2]
    assign pick_any  = rx_pick | tx_pick;
    assign rs_limit  = fc_mode_i ? RSFC_CYC : RS_CYC; // [RQ14]

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_START: begin
                if (timer_r >= START_CYC - 25'h1) begin
                    state_nxt = dis_lvl ? ST_OFF : ST_RUN; // [RQ18]
                end
            end
            ST_RUN: begin
                if (fault_latch_r) begin
                    state_nxt = ST_FAULT;
                end else if (dis_lvl) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_OFF: begin
                if (fault_latch_r) begin
                    state_nxt = ST_FAULT;
                end else if (!dis_lvl && timer_r >= ON_CYC - 25'h8) begin
                    state_nxt = ST_RUN; // [RQ7]
                end
            end
            ST_FAULT: begin
                if (!fault_latch_r && !dis_lvl) begin
                    state_nxt = ST_START; // [RQ18]
                end
            end
            default: state_nxt = ST_START;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r          <= ST_START;
            timer_r          <= 25'h0;
            init_cnt_r       <= 2'h0;
            init_r           <= 1'b1;
            laser_on_o       <= 1'b0;
            rx_los_o         <= 1'b1;
            module_missing_o <= 1'b0;
            serial_ready_o   <= 1'b0;
            operational_o    <= 1'b0;
        end else if (clk_en_i) begin
            // The filters preload until the synchronisers carry live pin levels.
            if (init_cnt_r != 2'h2) begin
                init_cnt_r <= init_cnt_r + 2'h1;
            end else begin
                init_r <= 1'b0;
            end
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                timer_r <= 25'h0;
            end else if (timer_r != 25'h1ffffff) begin
                timer_r <= timer_r + 25'h1;
            end
            laser_on_o <= (state_nxt == ST_RUN) & ~dis_lvl; // [RQ5] [RQ6]
            if (!init_r) begin
                rx_los_o <= los_lvl; // [RQ12] [RQ13]
            end
            module_missing_o <= 1'b0; // [RQ16]
            if (state_r == ST_START && timer_r >= START_CYC - 25'h1) begin
                serial_ready_o <= 1'b1; // [RQ17] [RQ21]
            end
            operational_o <= (state_nxt == ST_RUN) | (state_nxt == ST_OFF);
        end
    end

    // Fault latch: set wins; cleared only by a long-enough disable hold.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            dis_hold_r    <= 25'h0;
            fault_latch_r <= 1'b0;
            tx_fault_o    <= 1'b0;
        end else if (clk_en_i) begin
            if (dis_raw) begin
                if (dis_hold_r != 25'h1ffffff) begin
                    dis_hold_r <= dis_hold_r + 25'h1;
                end
            end else begin
                dis_hold_r <= 25'h0;
            end
            if (fault_lvl) begin
                fault_latch_r <= 1'b1; // [RQ8]
            end else if (dis_hold_r >= RST_CYC) begin
                fault_latch_r <= 1'b0; // [RQ10] [RQ22]
            end
            tx_fault_o <= fault_latch_r; // [RQ9]
        end
    end

    // Clock recovery steering.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_cdr_mode_o <= `CDR_LOCK_LOW;
            tx_cdr_mode_o <= `CDR_LOCK_LOW;
            cdr_rate_o    <= 4'h0;
        end else if (clk_en_i) begin
            if (!decode_on) begin
                rx_cdr_mode_o <= `CDR_LOCK_LOW;
                tx_cdr_mode_o <= `CDR_LOCK_LOW;
            end else begin
                case ({rx_pick, tx_pick}) // [RQ3]
                    2'h0: begin
                        rx_cdr_mode_o <= `CDR_LOCK_LOW;
                        tx_cdr_mode_o <= `CDR_LOCK_LOW;
                    end
                    2'h1: begin
                        rx_cdr_mode_o <= `CDR_LOCK_HIGH;
                        tx_cdr_mode_o <= `CDR_BYPASS;
                    end
                    2'h2: begin
                        rx_cdr_mode_o <= `CDR_BYPASS;
                        tx_cdr_mode_o <= `CDR_BYPASS;
                    end
                    default: begin
                        rx_cdr_mode_o <= `CDR_LOCK_HIGH;
                        tx_cdr_mode_o <= `CDR_LOCK_HIGH;
                    end
                endcase
            end
            cdr_rate_o <= rx_pick ? rate_id_i[7:4] : rate_id_i[3:0]; // [RQ4]
        end
    end

    // Settling timer restarted when the rate picks go from none set to at least one set.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rs_timer_r    <= 25'h0;
            pick_prev_r   <= 1'b0;
            rate_stable_o <= 1'b0;
        end else if (clk_en_i) begin
            pick_prev_r <= pick_any;
            if (pick_any && !pick_prev_r) begin
                rs_timer_r    <= 25'h0;
                rate_stable_o <= 1'b0;
            end else if (!rate_stable_o) begin
                if (rs_timer_r >= rs_limit - 25'h4) begin
                    rate_stable_o <= 1'b1; // [RQ14]
                end else begin
                    rs_timer_r <= rs_timer_r + 25'h1;
                end
            end
        end
    end

    // Power level changes take effect from the stop condition.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            pwr_timer_r     <= 25'h0;
            hp_pending_r    <= 1'b0;
            high_power_o    <= 1'b0;
            power_settled_o <= 1'b1;
        end else if (clk_en_i) begin
            if (stop_seen_i && high_power_req_i != high_power_o) begin
                high_power_o    <= high_power_req_i;
                hp_pending_r    <= 1'b1;
                pwr_timer_r     <= 25'h0;
                power_settled_o <= 1'b0;
            end else if (hp_pending_r) begin
                if (pwr_timer_r >= START_CYC - 25'h4) begin
                    hp_pending_r    <= 1'b0;
                    power_settled_o <= 1'b1; // [RQ19] [RQ20]
                end else begin
                    pwr_timer_r <= pwr_timer_r + 25'h1;
                end
            end
        end
    end
endmodule // optical_ctrl

// file: bench/optical_ctrl_props.sv
// Checker for the optical module control block.
`timescale 1ns/1ps
module optical_ctrl_props (
    // Watched ports.
    input wire       ref_clk_i, reset_i, clk_en_i, tx_disable_i, tx_disable_open_i,
    input wire       receive_rate_pick_i, transmit_rate_pick_i, soft_rx_pick_i,
    input wire       soft_tx_pick_i, rate_sel_en_i, high_power_req_i, stop_seen_i,
    input wire       laser_fault_i, signal_low_i, laser_on_o, tx_fault_o, rx_los_o,
    input wire       module_missing_o, rate_stable_o, high_power_o, serial_ready_o,
    input wire [7:0] rate_id_i,
    input wire [1:0] rx_cdr_mode_o, tx_cdr_mode_o
);
    reg  [10:0] low_cnt_r, high_cnt_r;
    reg  [7:0]  off_cnt_r;
    reg         off_q_r;
    wire        off = tx_disable_i | tx_disable_open_i;
    wire        ok = rate_id_i == 8'h0e && rate_sel_en_i;
    wire        rx_eff = receive_rate_pick_i | soft_rx_pick_i;
    wire        tx_eff = transmit_rate_pick_i | soft_tx_pick_i;
    wire [1:0]  rx_exp = !ok ? 2'h0 : rx_eff ? (tx_eff ? 2'h1 : 2'h2) : {1'b0, tx_eff};
    wire [1:0]  tx_exp = !ok ? 2'h0 : rx_eff == tx_eff ? {1'b0, rx_eff} : 2'h2;
    wire [2:0]  sel = {ok, rx_eff, tx_eff};
    // Run lengths of lost and present signal, and of the last transmit-off hold.
    always @(posedge ref_clk_i) begin
        off_q_r <= off;
        if (reset_i)
            off_cnt_r <= 8'h0;
        else if (off)
            off_cnt_r <= off_q_r ? off_cnt_r + {7'h0, off_cnt_r != 8'hff} : 8'h1;
        if (reset_i || !clk_en_i) begin
            low_cnt_r  <= 11'h0;
            high_cnt_r <= 11'h0;
        end else begin
            low_cnt_r  <= signal_low_i ? low_cnt_r + {10'h0, low_cnt_r != 11'h7ff} : 11'h0;
            high_cnt_r <= signal_low_i ? 11'h0 : high_cnt_r + {10'h0, high_cnt_r != 11'h7ff};
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i || !clk_en_i);
    a_presence_low: assert property (!module_missing_o)
        else $error("presence high");
    a_laser_off: assert property (off [*6] |-> !laser_on_o)
        else $error("laser not off");
    a_fault_set: assert property (laser_fault_i [*8] |-> tx_fault_o)
        else $error("fault not reported");
    a_fault_latch: assert property (!off [*6] ##0 tx_fault_o |=> tx_fault_o)
        else $error("fault dropped");
    a_fault_hold: assert property
        (!$past(reset_i) && $fell(tx_fault_o) |-> off_cnt_r >= 8'h64)
        else $error("fault cleared early");
    a_mode_table: assert property
        ($stable(sel) [*8] ##0 rate_stable_o
        |-> rx_cdr_mode_o == rx_exp && tx_cdr_mode_o == tx_exp)
        else $error("wrong recovery mode");
    a_los_set: assert property (low_cnt_r == 11'h3e8 |-> rx_los_o)
        else $error("loss not flagged");
    a_los_clear: assert property (high_cnt_r == 11'h3e8 |-> !rx_los_o)
        else $error("loss not released");
    a_power_take: assert property
        (stop_seen_i |=> high_power_o == $past(high_power_req_i))
        else $error("power level not taken");
    a_ready_keep: assert property (serial_ready_o |=> serial_ready_o)
        else $error("ready dropped");
    c_fault: cover property ($rose(tx_fault_o));
    c_power: cover property ($rose(high_power_o));
    c_los: cover property ($fell(rx_los_o));
endmodule // optical_ctrl_props
bind optical_ctrl optical_ctrl_props chk (.ref_clk_i, .reset_i, .clk_en_i, .tx_disable_i,
    .tx_disable_open_i, .receive_rate_pick_i, .transmit_rate_pick_i, .soft_rx_pick_i,
    .soft_tx_pick_i, .rate_sel_en_i, .high_power_req_i, .stop_seen_i, .laser_fault_i,
    .signal_low_i, .laser_on_o, .tx_fault_o, .rx_los_o, .module_missing_o, .rate_stable_o,
    .high_power_o, .serial_ready_o, .rate_id_i, .rx_cdr_mode_o, .tx_cdr_mode_o);

// file: bench/host_model.sv
// Host board controller model that drives the module control pins.
`timescale 1ns/1ps
module host_model (
    // Pins toward the module.
    input  wire ref_clk_i,
    output reg  tx_disable_o,
    output reg  rx_pick_o,
    output reg  tx_pick_o,
    output reg  power_req_o,
    output reg  stop_o
);
    initial {tx_disable_o, rx_pick_o, tx_pick_o, power_req_o, stop_o} = 5'h0;
    // Moves transmit-off and the rate picks on one clock edge.
    task pins(input reg off, input reg rx, input reg tx);
        begin
            @(posedge ref_clk_i);
            tx_disable_o <= off;
            rx_pick_o    <= rx;
            tx_pick_o    <= tx;
        end
    endtask
    // Holds transmit-off high for n cycles; 110 clears a fault.
    task hold_off(input integer n);
        begin
            pins(1'b1, rx_pick_o, tx_pick_o);
            repeat (n) @(posedge ref_clk_i);
            tx_disable_o <= 1'b0;
        end
    endtask
    // Ends a serial write that sets the power level request.
    task power(input reg req);
        begin
            @(posedge ref_clk_i);
            power_req_o <= req;
            stop_o      <= 1'b1;
            @(posedge ref_clk_i);
            stop_o      <= 1'b0;
        end
    endtask
endmodule // host_model

// file: bench/tb.sv
// Self-checking bench for the optical module control block.
`timescale 1ns/1ps
module tb;
    localparam START = 50, ON = 20, RS = 20;
    reg        ref_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, tx_disable_open_i = 1'b0;
    reg        soft_rx_pick_i = 1'b0, soft_tx_pick_i = 1'b0, rate_sel_en_i = 1'b1;
    reg        fc_mode_i = 1'b0, laser_fault_i = 1'b0, signal_low_i = 1'b0;
    reg  [7:0] rate_id_i = 8'h0e;
    wire       tx_disable_i, receive_rate_pick_i, transmit_rate_pick_i;
    wire       high_power_req_i, stop_seen_i, laser_on_o, tx_fault_o, rx_los_o;
    wire       module_missing_o, rate_stable_o, serial_ready_o, operational_o;
    wire       high_power_o, power_settled_o;
    wire [1:0] rx_cdr_mode_o, tx_cdr_mode_o;
    wire [3:0] cdr_rate_o;
    integer    num_errors = 0, comparisons = 0, cycles = 0, i;
    host_model host (.ref_clk_i, .tx_disable_o(tx_disable_i),
        .rx_pick_o(receive_rate_pick_i), .tx_pick_o(transmit_rate_pick_i),
        .power_req_o(high_power_req_i), .stop_o(stop_seen_i));
    optical_ctrl #(.START_CYC(START), .ON_CYC(ON), .RS_CYC(RS)) dut (.ref_clk_i, .reset_i,
        .clk_en_i, .tx_disable_i, .tx_disable_open_i, .receive_rate_pick_i,
        .transmit_rate_pick_i, .soft_rx_pick_i, .soft_tx_pick_i, .rate_id_i, .rate_sel_en_i,
        .fc_mode_i, .high_power_req_i, .stop_seen_i, .laser_fault_i, .signal_low_i,
        .laser_on_o, .tx_fault_o, .rx_los_o, .module_missing_o, .rx_cdr_mode_o,
        .tx_cdr_mode_o, .cdr_rate_o, .rate_stable_o, .serial_ready_o, .operational_o,
        .high_power_o, .power_settled_o);
    always #50 ref_clk_i = ~ref_clk_i;
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    // Waits n edges, then settles past the edge before sampling.
    task cyc(input integer n);
        begin
            repeat (n) @(posedge ref_clk_i);
            #10;
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    always @(posedge ref_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 50000) begin
            num_errors = num_errors + 1;
            tally_and_finish;
        end
    end
    initial begin
        cyc(5);
        chk(operational_o, 0);
        @(posedge ref_clk_i) reset_i <= 1'b0;
        cyc(START + 20);
        chk(serial_ready_o, 1);
        chk(operational_o, 1);
        chk(laser_on_o, 1);
        chk(module_missing_o, 0);
        cyc(1000);
        chk(rx_los_o, 0);
        $display("start-up test done");
        host.pins(1'b1, 1'b0, 1'b0);
        cyc(1000);
        chk(laser_on_o, 0);
        host.pins(1'b0, 1'b0, 1'b0);
        cyc(ON + 12);
        chk(laser_on_o, 1);
        @(posedge ref_clk_i) tx_disable_open_i <= 1'b1;
        cyc(1000);
        chk(laser_on_o, 0);
        @(posedge ref_clk_i) tx_disable_open_i <= 1'b0;
        cyc(ON + 12);
        chk(laser_on_o, 1);
        $display("transmit-off test done");
        @(posedge ref_clk_i) laser_fault_i <= 1'b1;
        cyc(10000);
        chk(tx_fault_o, 1);
        @(posedge ref_clk_i) laser_fault_i <= 1'b0;
        cyc(200);
        chk(tx_fault_o, 1);
        host.hold_off(50);
        cyc(10);
        chk(tx_fault_o, 1);
        host.hold_off(110);
        cyc(10);
        chk(tx_fault_o, 0);
        cyc(START + 30);
        chk(laser_on_o, 1);
        $display("fault test done");
        // Pairs from pins first, then from the software bits in fibre channel timing.
        for (i = 0; i < 8; i = i + 1) begin
            host.pins(1'b0, i[1] & !i[2], i[0] & !i[2]);
            soft_rx_pick_i <= i[1] & i[2];
            soft_tx_pick_i <= i[0] & i[2];
            fc_mode_i      <= i[2];
            cyc(i[2] ? 5000 : RS + 10);
            chk(rx_cdr_mode_o, (8'h64 >> (2 * i[1:0])) & 8'h3);
            chk(tx_cdr_mode_o, (8'h68 >> (2 * i[1:0])) & 8'h3);
            chk(rate_stable_o, 1);
            if (i[0] == i[1])
                chk(cdr_rate_o, i[0] ? 8'h0 : 8'he);
        end
        host.pins(1'b0, 1'b1, 1'b1);
        soft_rx_pick_i <= 1'b0;
        soft_tx_pick_i <= 1'b0;
        rate_sel_en_i  <= 1'b0;
        cyc(RS + 10);
        chk({rx_cdr_mode_o, tx_cdr_mode_o}, 8'h0);
        @(posedge ref_clk_i) {rate_sel_en_i, rate_id_i} <= 9'h10f;
        cyc(RS + 10);
        chk({rx_cdr_mode_o, tx_cdr_mode_o}, 8'h0);
        @(posedge ref_clk_i) rate_id_i <= 8'h0e;
        cyc(RS + 10);
        chk({rx_cdr_mode_o, tx_cdr_mode_o}, 8'h5);
        $display("rate select test done");
        @(posedge ref_clk_i) signal_low_i <= 1'b1;
        cyc(1000);
        chk(rx_los_o, 1);
        @(posedge ref_clk_i) signal_low_i <= 1'b0;
        cyc(1000);
        chk(rx_los_o, 0);
        for (i = 1; i >= 0; i = i - 1) begin
            host.power(i[0]);
            cyc(1);
            chk({high_power_o, power_settled_o}, {7'h0, i[0]} << 1);
            cyc(START + 10);
            chk(power_settled_o, 1);
        end
        $display("loss and power test done");
        // A low clock enable freezes the block, so a new transmit-off waits for it.
        @(posedge ref_clk_i) clk_en_i <= 1'b0;
        host.pins(1'b1, 1'b1, 1'b1);
        cyc(20);
        chk(laser_on_o, 1);
        @(posedge ref_clk_i) clk_en_i <= 1'b1;
        cyc(10);
        chk(laser_on_o, 0);
        host.pins(1'b0, 1'b1, 1'b1);
        $display("clock enable test done");
        @(posedge ref_clk_i) reset_i <= 1'b1;
        cyc(3);
        chk({rx_los_o, operational_o}, 8'h2);
        @(posedge ref_clk_i) reset_i <= 1'b0;
        cyc(START + 20);
        chk(operational_o, 1);
        $display("reset test done");
        tally_and_finish;
    end
endmodule // tb
